// [rtl/port_pin_control.sv]
// Purpose: port B/C pin control, port A input-enable overrides, pin-change flag
// Assumes: AXI4-Lite slave, pins synchronous to aclk, one clock
// Notes: unmapped addresses answer SLVERR; writes need the low byte lane strobe
//
// Function
// - reading port C input sample returns pin levels, direction ignored
// - writing one to input sample bit toggles output bit; zero leaves it
// - port B pull-up enabled exactly while its pull-up bit is set
// - port B output pin driven to its output-data bit
// - input-configured pin is not driven; output-data bit ignored
// - port B direction bit one means output, zero means input
// - port A pins 0-2 override enables and values tied to zero
// - pin 0 input override when mask and group enable, or analog disable
// - pin 1 override value is mask and group enable; enable adds disable
// - pin 2 same override; digital to pin change, analog to converter
// - flag 3 set by masked change on pin-change inputs 27:24
// - group 3 interrupt requested only with flag, global and group enable; irq ignores global and group enable
// - flag 3 cleared on interrupt entry or software write of one
// - flag register bits 7:4 always read zero
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module port_pin_control
#(
    parameter int WIDTH = gpio_pkg::PORT_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [gpio_pkg::ADDR_W-1:0] s_axil_awaddr,
    input wire logic [2:0] s_axil_awprot,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [gpio_pkg::ADDR_W-1:0] s_axil_araddr,
    input wire logic [2:0] s_axil_arprot,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [WIDTH-1:0] port_b_pin_in,
    output logic [WIDTH-1:0] port_b_pin_out,
    output logic [WIDTH-1:0] port_b_pin_oe,
    output logic [WIDTH-1:0] port_b_pullup_on,
    input wire logic [WIDTH-1:0] port_c_pin_in,
    output logic [WIDTH-1:0] port_c_pin_out,
    output logic [WIDTH-1:0] port_c_pin_oe,
    input wire logic [gpio_pkg::NUM_ANALOG-1:0] port_a_pin_in,
    input wire logic [gpio_pkg::PC_GROUP_W-1:0] pin_change_group3_in,
    output logic [gpio_pkg::NUM_ANALOG-1:0] input_enable_override_enable,
    output logic [gpio_pkg::NUM_ANALOG-1:0] input_enable_override_value,
    output logic [gpio_pkg::NUM_ANALOG-1:0] port_a_override_zero,
    output logic [gpio_pkg::NUM_ANALOG-1:0] digital_input_route,
    output logic pin_change_irq_req,
    output logic irq
);
    import gpio_pkg::*;

    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("WIDTH must be 1 to 32");
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [WIDTH-1:0] port_b_output_data_q;
    logic [WIDTH-1:0] port_b_pullup_enable_q;
    logic [WIDTH-1:0] port_b_direction_q;
    logic [WIDTH-1:0] port_c_output_data_q;
    logic [WIDTH-1:0] port_c_direction_q;
    logic [7:0] pin_change_control_q;
    logic [PC_GROUP_W-1:0] pc_mask3_q;
    logic [NUM_ANALOG-1:0] pc_mask0_q;
    logic [NUM_ANALOG-1:0] analog_digital_disable_q;
    logic gie_q;
    logic flag3_q;
    logic [EV_W-1:0] int_status_q;
    logic [EV_W-1:0] int_enable_q;

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic [5:0] wr_idx;
    logic wr_ok;
    logic [7:0] wb;

    assign wr_fire = aw_held_q && w_held_q && !s_axil_bvalid;
    assign wr_idx = awaddr_q[7:2];
    assign wb = wdata_q[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (s_axil_awvalid && s_axil_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axil_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axil_wdata;
                wstrb_q <= s_axil_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_awready <= 1'b0;
            s_axil_wready <= 1'b0;
        end else begin
            s_axil_awready <= !aw_held_q && !(s_axil_awvalid && s_axil_awready) && !wr_fire;
            s_axil_wready <= !w_held_q && !(s_axil_wvalid && s_axil_wready) && !wr_fire;
        end
    end

    always_comb begin
        unique case (wr_idx)
            IDX_PORT_B_OUT, IDX_PORT_B_PUE, IDX_PORT_C_IN, IDX_PORT_B_DIR,
            IDX_PORT_C_OUT, IDX_PORT_C_DIR, IDX_PC_FLAGS, IDX_PC_CTRL,
            IDX_PC_MASK3, IDX_PC_MASK0, IDX_ADC_DIS, IDX_GIE, IDX_IRQ_ACK,
            IDX_INT_ENABLE, IDX_INT_CLEAR: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    logic we;
    assign we = wr_fire && wr_ok && wstrb_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axil_bvalid <= 1'b1;
            s_axil_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axil_bready) begin
            s_axil_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // port b and c control registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_b_output_data_q <= '0;
            port_b_pullup_enable_q <= '0;
            port_b_direction_q <= '0;
            port_c_direction_q <= '0;
        end else if (we) begin
            if (wr_idx == IDX_PORT_B_OUT) port_b_output_data_q <= wdata_q[WIDTH-1:0];
            if (wr_idx == IDX_PORT_B_PUE) port_b_pullup_enable_q <= wdata_q[WIDTH-1:0];
            if (wr_idx == IDX_PORT_B_DIR) port_b_direction_q <= wdata_q[WIDTH-1:0];
            if (wr_idx == IDX_PORT_C_DIR) port_c_direction_q <= wdata_q[WIDTH-1:0];
        end
    end

    // toggle ignores direction bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_c_output_data_q <= '0;
        end else if (we && wr_idx == IDX_PORT_C_IN) begin
            port_c_output_data_q <= port_c_output_data_q ^ wdata_q[WIDTH-1:0];
        end else if (we && wr_idx == IDX_PORT_C_OUT) begin
            port_c_output_data_q <= wdata_q[WIDTH-1:0];
        end
    end

    // ************************************************************
    // pin-change and analog control
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_change_control_q <= RESET_BYTE;
            pc_mask3_q <= '0;
            pc_mask0_q <= '0;
            analog_digital_disable_q <= '0;
            gie_q <= 1'b0;
            int_enable_q <= '0;
        end else if (we) begin
            if (wr_idx == IDX_PC_CTRL) pin_change_control_q <= wb;
            if (wr_idx == IDX_PC_MASK3) pc_mask3_q <= wb[PC_GROUP_W-1:0];
            if (wr_idx == IDX_PC_MASK0) pc_mask0_q <= wb[NUM_ANALOG-1:0];
            if (wr_idx == IDX_ADC_DIS) analog_digital_disable_q <= wb[NUM_ANALOG-1:0];
            if (wr_idx == IDX_GIE) gie_q <= wb[0];
            if (wr_idx == IDX_INT_ENABLE) int_enable_q <= wb[EV_W-1:0];
        end
    end

    pin_change_if #(.W(PC_GROUP_W)) pc3 ();
    assign pc3.pins = pin_change_group3_in;
    assign pc3.mask = pc_mask3_q;

    pin_change_detect u_pc3 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pc(pc3)
    );

    logic clr_sw;
    logic clr_isr;
    assign clr_sw = we && wr_idx == IDX_PC_FLAGS && wb[FLAG_GROUP3];
    assign clr_isr = we && wr_idx == IDX_IRQ_ACK && wb[0];

    // set wins so a change during the clear is kept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag3_q <= 1'b0;
        end else if (pc3.event_p) begin
            flag3_q <= 1'b1;
        end else if (clr_sw || clr_isr) begin
            flag3_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_status_q <= '0;
        end else begin
            for (int i = 0; i < EV_W; i++) begin
                if (i == EV_PC3 && pc3.event_p) begin
                    int_status_q[i] <= 1'b1;
                end else if (we && wr_idx == IDX_INT_CLEAR && wb[i]) begin
                    int_status_q[i] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // pin outputs
    // ************************************************************
    logic [NUM_ANALOG-1:0] pc_term;
    assign pc_term = pc_mask0_q & {NUM_ANALOG{pin_change_control_q[PC_CTRL_GROUP0]}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_b_pin_out <= '0;
            port_b_pin_oe <= '0;
            port_b_pullup_on <= '0;
            port_c_pin_out <= '0;
            port_c_pin_oe <= '0;
        end else begin
            port_b_pin_oe <= port_b_direction_q;
            port_b_pin_out <= port_b_output_data_q & port_b_direction_q;
            port_b_pullup_on <= port_b_pullup_enable_q;
            port_c_pin_oe <= port_c_direction_q;
            port_c_pin_out <= port_c_output_data_q & port_c_direction_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            input_enable_override_enable <= '0;
            input_enable_override_value <= '0;
            port_a_override_zero <= '0;
            digital_input_route <= '0;
        end else begin
            input_enable_override_enable <= pc_term | analog_digital_disable_q;
            input_enable_override_value <= pc_term;
            port_a_override_zero <= '0;
            digital_input_route <= port_a_pin_in;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_change_irq_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            pin_change_irq_req <= flag3_q && gie_q && pin_change_control_q[PC_CTRL_GROUP3];
            irq <= |(int_status_q & int_enable_q);
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    logic [31:0] rd_data;
    logic rd_ok;
    logic [5:0] rd_idx;
    assign rd_idx = s_axil_araddr[7:2];

    always_comb begin
        rd_data = '0;
        rd_ok = 1'b1;
        unique case (rd_idx)
            IDX_PORT_B_OUT: rd_data[WIDTH-1:0] = port_b_output_data_q;
            IDX_PORT_B_PUE: rd_data[WIDTH-1:0] = port_b_pullup_enable_q;
            IDX_PORT_C_IN: rd_data[WIDTH-1:0] = port_c_pin_in;
            IDX_PORT_B_DIR: rd_data[WIDTH-1:0] = port_b_direction_q;
            IDX_PORT_C_OUT: rd_data[WIDTH-1:0] = port_c_output_data_q;
            IDX_PORT_C_DIR: rd_data[WIDTH-1:0] = port_c_direction_q;
            IDX_PC_FLAGS: rd_data[FLAG_GROUP3] = flag3_q;
            IDX_PC_CTRL: rd_data[7:0] = pin_change_control_q;
            IDX_PC_MASK3: rd_data[PC_GROUP_W-1:0] = pc_mask3_q;
            IDX_PC_MASK0: rd_data[NUM_ANALOG-1:0] = pc_mask0_q;
            IDX_ADC_DIS: rd_data[NUM_ANALOG-1:0] = analog_digital_disable_q;
            IDX_GIE: rd_data[0] = gie_q;
            IDX_INT_STATUS: rd_data[EV_W-1:0] = int_status_q;
            IDX_INT_ENABLE: rd_data[EV_W-1:0] = int_enable_q;
            IDX_IRQ_ACK, IDX_INT_CLEAR: rd_data = '0;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_arready <= 1'b0;
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= '0;
            s_axil_rresp <= RESP_OKAY;
        end else if (s_axil_arvalid && s_axil_arready) begin
            s_axil_arready <= 1'b0;
            s_axil_rvalid <= 1'b1;
            s_axil_rdata <= rd_data;
            s_axil_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axil_rvalid) begin
            if (s_axil_rready) begin
                s_axil_rvalid <= 1'b0;
            end
        end else begin
            s_axil_arready <= 1'b1;
        end
    end
endmodule

// [rtl/gpio_pkg.sv]
// Purpose: constants shared by the port pin control block
// Assumes: AXI4-Lite register bus, 32-bit data, word-aligned registers
// Notes: printed offsets are not multiples of four, so they are indices
package gpio_pkg;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;
    localparam int PC_GROUP_W = 4;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_PORT_B_OUT = 6'h06;
    localparam logic [5:0] IDX_PORT_B_PUE = 6'h07;
    localparam logic [5:0] IDX_PORT_C_IN = 6'h08;
    localparam logic [5:0] IDX_PORT_B_DIR = 6'h09;
    localparam logic [5:0] IDX_PORT_C_OUT = 6'h0A;
    localparam logic [5:0] IDX_PORT_C_DIR = 6'h0B;
    localparam logic [5:0] IDX_PC_FLAGS = 6'h0C;
    localparam logic [5:0] IDX_PC_CTRL = 6'h0D;
    localparam logic [5:0] IDX_PC_MASK3 = 6'h0E;
    localparam logic [5:0] IDX_PC_MASK0 = 6'h0F;
    localparam logic [5:0] IDX_ADC_DIS = 6'h10;
    localparam logic [5:0] IDX_GIE = 6'h11;
    localparam logic [5:0] IDX_IRQ_ACK = 6'h12;
    localparam logic [5:0] IDX_INT_STATUS = 6'h13;
    localparam logic [5:0] IDX_INT_ENABLE = 6'h14;
    localparam logic [5:0] IDX_INT_CLEAR = 6'h15;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int FLAG_GROUP3 = 3;
    localparam int PC_CTRL_GROUP0 = 0;
    localparam int PC_CTRL_GROUP3 = 3;
    localparam int NUM_ANALOG = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // interrupt status layout
    localparam int EV_PC3 = 0;
    localparam int EV_W = 1;
endpackage

// [rtl/pin_change_if.sv]
// Purpose: one pin-change group, detector to register file
// Assumes: all signals on aclk
// Notes: event is a one-cycle pulse
`timescale 1ns/1ps
interface pin_change_if #(parameter int W = 4);
    logic [W-1:0] pins;
    logic [W-1:0] mask;
    logic event_p;
    modport det (input pins, input mask, output event_p);
    modport ctl (output pins, output mask, input event_p);
endinterface

// [rtl/pin_change_detect.sv]
// Purpose: detects a logic change on any masked pin of a group
// Assumes: pins already synchronous to aclk
// Notes: first cycle after reset never reports a change
`timescale 1ns/1ps
module pin_change_detect (
    input wire logic aclk,
    input wire logic aresetn,
    pin_change_if.det pc
);
    logic [$bits(pc.pins)-1:0] last_q;
    logic armed_q;
    logic event_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_q <= '0;
            armed_q <= 1'b0;
        end else begin
            last_q <= pc.pins;
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_q <= 1'b0;
        end else begin
            event_q <= armed_q && |((last_q ^ pc.pins) & pc.mask);
        end
    end

    assign pc.event_p = event_q;
endmodule

// [verif/port_pin_control_props.sv]
// Purpose: concurrent checks on the port pin control ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: pin outputs settle one cycle after the write response rises
`timescale 1ns/1ps
module port_pin_control_props
    import gpio_pkg::*;
#(
    parameter int WIDTH = gpio_pkg::PORT_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axil_bresp,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [1:0] s_axil_rresp,
    input wire logic s_axil_rvalid,
    input wire logic [WIDTH-1:0] port_b_pin_out,
    input wire logic [WIDTH-1:0] port_b_pin_oe,
    input wire logic [WIDTH-1:0] port_b_pullup_on,
    input wire logic [gpio_pkg::NUM_ANALOG-1:0] port_a_pin_in,
    input wire logic [gpio_pkg::NUM_ANALOG-1:0] input_enable_override_enable,
    input wire logic [gpio_pkg::NUM_ANALOG-1:0] input_enable_override_value,
    input wire logic [gpio_pkg::NUM_ANALOG-1:0] port_a_override_zero,
    input wire logic [gpio_pkg::NUM_ANALOG-1:0] digital_input_route,
    input wire logic pin_change_irq_req,
    input wire logic irq
);
    // ****
    // helper and checks
    // ****
    // history checks wait out reset
    logic [1:0] up_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_pullup_by_write: assert property (up_q == 2'h3 && $changed(port_b_pullup_on)
        |-> $past(s_axil_bvalid)) else $error("pull-up changed unwritten");
    a_out_gated_oe: assert property ((port_b_pin_out & ~port_b_pin_oe) == '0)
        else $error("data on an input pin");
    a_dir_by_write: assert property (up_q == 2'h3 && $changed(port_b_pin_oe)
        |-> $past(s_axil_bvalid)) else $error("direction changed unwritten");
    a_override_tied: assert property (port_a_override_zero == '0)
        else $error("port A override not zero");
    a_input_enable_override_value_in_input_enable_override_enable: assert property ((input_enable_override_value
        & ~input_enable_override_enable) == '0) else $error("override value without enable");
    a_route_tracks: assert property (up_q == 2'h3 |->
        digital_input_route == $past(port_a_pin_in)) else $error("input route stale");
    a_req_drop_write: assert property (up_q == 2'h3 && $fell(pin_change_irq_req)
        |-> $past(s_axil_bvalid)) else $error("request fell alone");
    a_irq_drop_write: assert property (up_q == 2'h3 && $fell(irq)
        |-> $past(s_axil_bvalid)) else $error("irq fell alone");
    a_resp_holds: assert property (s_axil_bvalid && !s_axil_bready
        |=> s_axil_bvalid && $stable(s_axil_bresp)) else $error("write response not held");
    c_req_rise: cover property ($rose(pin_change_irq_req));
    c_irq_rise: cover property ($rose(irq));
    c_read_err: cover property (s_axil_rvalid && s_axil_rresp == RESP_SLVERR);
endmodule

bind port_pin_control port_pin_control_props #(.WIDTH(WIDTH)) port_pin_control_props_i (
    .aclk, .aresetn, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_rresp,
    .s_axil_rvalid, .port_b_pin_out, .port_b_pin_oe, .port_b_pullup_on, .port_a_pin_in,
    .input_enable_override_enable, .input_enable_override_value, .port_a_override_zero,
    .digital_input_route, .pin_change_irq_req, .irq
);

// [verif/pin_board_model.sv]
// Purpose: board side of the port B and port C pins
// Assumes: levels resolve without delay
// Notes: released port B pins show pull-up, else board level
`timescale 1ns/1ps
module pin_board_model (
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oe,
    input wire logic [7:0] b_pu,
    input wire logic [7:0] b_ext,
    input wire logic [7:0] c_out,
    input wire logic [7:0] c_oe,
    input wire logic [7:0] c_ext,
    output logic [7:0] b_pin,
    output logic [7:0] c_pin
);
    // ****
    // pin resolution
    // ****
    assign b_pin = (b_oe & b_out) | (~b_oe & (b_pu | b_ext));
    assign c_pin = (c_oe & c_out) | (~c_oe & c_ext);
endmodule

// [verif/tb_port_pin_control.sv]
// Purpose: self-checking bench for the port pin control block
// Assumes: 125 MHz aclk, synchronous active-low reset
// Notes: expectations come from a register model kept in the bench
`timescale 1ns/1ps
module tb_port_pin_control;
    import gpio_pkg::*;
    logic aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
    logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
    logic s_axil_rready, pin_change_irq_req, irq;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    logic [2:0] s_axil_awprot, s_axil_arprot, port_a_pin_in, port_a_override_zero;
    logic [2:0] input_enable_override_enable, input_enable_override_value, digital_input_route;
    logic [3:0] s_axil_wstrb, pin_change_group3_in, g;
    logic [7:0] s_axil_awaddr, s_axil_araddr, port_b_pin_in, port_b_pin_out, port_b_pin_oe;
    logic [7:0] port_b_pullup_on, port_c_pin_in, port_c_pin_out, port_c_pin_oe, b_ext, c_ext;
    logic [7:0] bo, bp, bd, co, cd, ce, t, m, c, a, pa;
    logic [31:0] s_axil_wdata, s_axil_rdata, seed;
    int fails = 0, check_count = 0;

    always #4 aclk = ~aclk;

    port_pin_control port_pin_control_i (
        .aclk, .aresetn, .s_axil_awaddr, .s_axil_awprot, .s_axil_awvalid, .s_axil_awready,
        .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
        .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arprot, .s_axil_arvalid,
        .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
        .port_b_pin_in, .port_b_pin_out, .port_b_pin_oe, .port_b_pullup_on, .port_c_pin_in,
        .port_c_pin_out, .port_c_pin_oe, .port_a_pin_in, .pin_change_group3_in,
        .input_enable_override_enable, .input_enable_override_value, .port_a_override_zero,
        .digital_input_route, .pin_change_irq_req, .irq
    );
    pin_board_model pin_board_model_i (
        .b_out(port_b_pin_out), .b_oe(port_b_pin_oe), .b_pu(port_b_pullup_on), .b_ext,
        .c_out(port_c_pin_out), .c_oe(port_c_pin_oe), .c_ext, .b_pin(port_b_pin_in),
        .c_pin(port_c_pin_in)
    );

    // ****
    // helpers
    // ****
    function automatic logic [7:0] nx();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic chk(input logic [39:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] ix, input logic [7:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_axil_awaddr <= {ix, 2'h0};
        s_axil_wdata <= {24'h0, d};
        {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            n++;
            if (s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wready) s_axil_wvalid <= 1'b0;
        end while (!s_axil_bvalid && n < 50);
        s_axil_bready <= 1'b0;
        chk({s_axil_bvalid, s_axil_bresp}, {1'b1, er});
    endtask
    task automatic rd(input logic [5:0] ix, input logic [7:0] ed, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_axil_araddr <= {ix, 2'h0};
        {s_axil_arvalid, s_axil_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            n++;
            if (s_axil_arready) s_axil_arvalid <= 1'b0;
        end while (!s_axil_rvalid && n < 50);
        s_axil_rready <= 1'b0;
        chk({s_axil_rvalid, s_axil_rresp, s_axil_rdata}, {1'b1, er, 24'h0, ed});
    endtask
    // pin outputs lag the register by one cycle
    task automatic settle();
        repeat (2) @(posedge aclk);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ****
    // tests
    // ****
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
        {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
        {s_axil_awprot, s_axil_arprot, port_a_pin_in} = '0;
        s_axil_wstrb = 4'hF;
        {pin_change_group3_in, g, b_ext, c_ext} = '0;
        seed = 32'h00016ADB;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(IDX_PORT_B_OUT, 8'h00, RESP_OKAY);
        rd(IDX_PORT_B_PUE, 8'h00, RESP_OKAY);
        rd(6'h3F, 8'h00, RESP_SLVERR);
        wr(IDX_INT_STATUS, 8'hFF, RESP_SLVERR);
        $display("test map done");
        for (int i = 0; i < 6; i++) begin
            bo = nx();
            bp = nx();
            bd = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : nx();
            b_ext <= nx();
            wr(IDX_PORT_B_OUT, bo, RESP_OKAY);
            wr(IDX_PORT_B_PUE, bp, RESP_OKAY);
            wr(IDX_PORT_B_DIR, bd, RESP_OKAY);
            rd(IDX_PORT_B_DIR, bd, RESP_OKAY);
            chk(port_b_pin_oe, bd);
            chk(port_b_pin_out, bo & bd);
            chk(port_b_pullup_on, bp);
        end
        $display("test port b done");
        for (int i = 0; i < 6; i++) begin
            co = nx();
            cd = nx();
            ce = nx();
            t = (i == 0) ? 8'h00 : nx();
            c_ext <= ce;
            wr(IDX_PORT_C_OUT, co, RESP_OKAY);
            wr(IDX_PORT_C_DIR, cd, RESP_OKAY);
            rd(IDX_PORT_C_IN, (cd & co) | (~cd & ce), RESP_OKAY);
            wr(IDX_PORT_C_IN, t, RESP_OKAY);
            co = co ^ t;
            rd(IDX_PORT_C_OUT, co, RESP_OKAY);
            chk({port_c_pin_out, port_c_pin_oe}, {co & cd, cd});
        end
        $display("test port c done");
        for (int i = 0; i < 8; i++) begin
            m = (i == 0) ? 8'h07 : nx();
            c = (i == 0) ? 8'h01 : nx() & 8'hF7;
            a = (i == 0) ? 8'h00 : nx();
            pa = nx();
            port_a_pin_in <= pa[2:0];
            wr(IDX_PC_MASK0, m, RESP_OKAY);
            wr(IDX_PC_CTRL, c, RESP_OKAY);
            wr(IDX_ADC_DIS, a, RESP_OKAY);
            settle();
            chk(input_enable_override_value, m[2:0] & {3{c[0]}});
            chk(input_enable_override_enable, (m[2:0] & {3{c[0]}}) | a[2:0]);
            chk(digital_input_route, pa[2:0]);
            chk(port_a_override_zero, 3'h0);
        end
        $display("test overrides done");
        wr(IDX_PC_MASK3, 8'h0F, RESP_OKAY);
        wr(IDX_PC_CTRL, 8'h08, RESP_OKAY);
        wr(IDX_GIE, 8'h01, RESP_OKAY);
        wr(IDX_INT_ENABLE, 8'h01, RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            g[i % 4] = ~g[i % 4];
            pin_change_group3_in <= g;
            repeat (4) @(posedge aclk);
            rd(IDX_PC_FLAGS, 8'h08, RESP_OKAY);
            chk({pin_change_irq_req, irq}, 2'h3);
            if (i == 4) begin
                // masking by each enable
                wr(IDX_GIE, 8'h00, RESP_OKAY);
                wr(IDX_INT_ENABLE, 8'h00, RESP_OKAY);
                settle();
                chk({pin_change_irq_req, irq}, 2'h0);
                wr(IDX_GIE, 8'h01, RESP_OKAY);
                wr(IDX_PC_CTRL, 8'h00, RESP_OKAY);
                settle();
                chk(pin_change_irq_req, 1'b0);
                wr(IDX_PC_CTRL, 8'h08, RESP_OKAY);
                wr(IDX_INT_ENABLE, 8'h01, RESP_OKAY);
            end
            if (i[0]) wr(IDX_IRQ_ACK, 8'h01, RESP_OKAY);
            else wr(IDX_PC_FLAGS, 8'hF8, RESP_OKAY);
            wr(IDX_INT_CLEAR, 8'h01, RESP_OKAY);
            settle();
            rd(IDX_PC_FLAGS, 8'h00, RESP_OKAY);
            chk({pin_change_irq_req, irq}, 2'h0);
        end
        wr(IDX_PC_MASK3, 8'h00, RESP_OKAY);
        g = ~g;
        pin_change_group3_in <= g;
        repeat (4) @(posedge aclk);
        rd(IDX_PC_FLAGS, 8'h00, RESP_OKAY);
        wr(IDX_PC_MASK3, 8'h0F, RESP_OKAY);
        wr(IDX_PC_FLAGS, 8'h08, RESP_OKAY);
        // change lands on the same edge as the clear below
        g[0] = ~g[0];
        pin_change_group3_in <= #8 g;
        wr(IDX_PC_FLAGS, 8'h08, RESP_OKAY);
        settle();
        rd(IDX_PC_FLAGS, 8'h08, RESP_OKAY);
        $display("test pin change done");
        give_verdict();
    end

    // run takes about 500 cycles
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule
